// file: pcc_defines.svh
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH
// clock and timing
`define PCC_CLK_NS 50
`define PCC_REF_WIN_NS 500
`define PCC_REF_WIN_CYC ((`PCC_REF_WIN_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
// cadence geometry
`define PCC_DELAY_FRAMES 4
`define PCC_SLOT_W 2
`define PCC_CADENCE_FRAMES 3'h4
`define PCC_FIELDS_SHORT 2'h2
`define PCC_FIELDS_LONG 2'h3
`define PCC_PHASE_A 2'h0
`define PCC_TC_MOD_MASK 6'h03
`define PCC_TC_OUT_GROUP 5'h05
// register map
`define PCC_ADDR_W 4
`define PCC_REG_CTRL 4'h0
`define PCC_REG_STATUS 4'h4
`define PCC_REG_FRAMES 4'h8
`define PCC_CTRL_RESET 8'h11
`define PCC_CTRL_REF_EN 0
`define PCC_CTRL_FILL_LSB 1
`define PCC_CTRL_FILL_MSB 2
`define PCC_CTRL_CHARS 3
`define PCC_CTRL_SD_OUT 4
`define PCC_CTRL_ASPECT_LSB 5
`define PCC_CTRL_ASPECT_MSB 6
`define PCC_CTRL_FILM 7
`endif

// file: pcc_pkg.sv
package pcc_pkg;
  // timecode address
  typedef struct packed {
    logic [5:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [5:0] frames;
  } pcc_tc_type;

  // one progressive input frame as seen by this block
  typedef struct packed {
    logic [15:0] picture;
    logic [15:0] audio;
    pcc_tc_type tc;
  } pcc_in_frame_type;

  typedef enum logic [1:0] {PCC_FILL_BLUE, PCC_FILL_BLACK, PCC_FILL_PASS} pcc_fill_type;
  typedef enum logic [1:0] {PCC_ASPECT_ANAMORPHIC, PCC_ASPECT_LETTERBOX, PCC_ASPECT_CROP}
    pcc_aspect_type;

  // one interlaced output field
  typedef struct packed {
    logic [15:0] picture;
    logic [15:0] audio;
    pcc_tc_type tc;
    logic oddField;
    logic [1:0] cadence;
    logic lost;
    pcc_fill_type fill;
    logic chars;
    logic sdOut;
    pcc_aspect_type aspect;
    logic threeLineVitc;
  } pcc_out_field_type;

  typedef enum logic {PCC_IDLE, PCC_EMIT} pcc_emit_state_type;
endpackage : pcc_pkg

// file: pcc_cadence_converter.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`include "pcc_defines.svh"

// Behaviour
// - 23.98p input becomes 2:3 interlaced output
// - cadence from reference pulse or timecode
// - reference-marked frame becomes two-field A frame
// - marked frame leaves four frames later, two fields
// - without reference, frame number multiple of four
// - fixed four-frame latency aligns output A frames
// - audio delayed with picture, reinserted in step
// - on loss output blue, black or pass
// - timecode converted 24 to 30, retimed
// - dual-link RGB to 4:2:2 HD or SD
// - aspect anamorphic, letterbox or centre crop
// - film mode gives three-line VITC
// - video mode gives standard VITC
// - frames alternate two and three fields
module pcc_cadence_converter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic inFrameStart,
  input wire pcc_pkg::pcc_in_frame_type inFrame,
  input wire logic refPulsePin,
  input wire logic videoPresentPin,
  output pcc_pkg::pcc_out_field_type outField,
  output logic outValid,
  input wire logic outReady,
  input wire logic [`PCC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and filters

  logic [1:0] pinRaw;
  logic [1:0] pinS1_r;
  logic [1:0] pinS2_r;
  logic [1:0] pinS3_r;
  logic [1:0] pinLevel_r;
  logic [1:0] pinLevelDly_r;
  assign pinRaw = {videoPresentPin, refPulsePin};

  // three flops, level accepted when second and third agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gSync
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          pinS1_r[gi] <= 1'b0;
          pinS2_r[gi] <= 1'b0;
          pinS3_r[gi] <= 1'b0;
          pinLevel_r[gi] <= 1'b0;
          pinLevelDly_r[gi] <= 1'b0;
        end else begin
          pinS1_r[gi] <= pinRaw[gi];
          pinS2_r[gi] <= pinS1_r[gi];
          pinS3_r[gi] <= pinS2_r[gi];
          if (pinS2_r[gi] == pinS3_r[gi]) begin
            pinLevel_r[gi] <= pinS3_r[gi];
          end
          pinLevelDly_r[gi] <= pinLevel_r[gi];
        end
      end
    end
  endgenerate

  logic refEdge;
  logic videoLost;
  assign refEdge = pinLevel_r[0] & ~pinLevelDly_r[0];
  assign videoLost = ~pinLevel_r[1];

  ////////////////////////////////////////////////////////////////////////
  // register port

  logic [7:0] ctrl_r;
  logic [15:0] frameCount_r;
  logic overrun_r;
  logic refPresent_r;
  logic [1:0] phase_r;
  logic [1:0] bufCount_r;

  // control register write
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_r <= `PCC_CTRL_RESET;
    end else if (regWr && regAddr == `PCC_REG_CTRL) begin
      ctrl_r <= regWdata[7:0];
    end
  end

  // read data one cycle after strobe, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `PCC_REG_CTRL: regRdata <= {24'h0, ctrl_r};
        `PCC_REG_STATUS: regRdata <= {26'h0, bufCount_r, phase_r, videoLost, refPresent_r};
        `PCC_REG_FRAMES: regRdata <= {15'h0, overrun_r, frameCount_r};
        default: regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

  logic refEnable;
  assign refEnable = ctrl_r[`PCC_CTRL_REF_EN];

  ////////////////////////////////////////////////////////////////////////
  // reference presence

  logic [2:0] framesSinceRef_r;
  logic [4:0] sinceStart_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      framesSinceRef_r <= 3'h0;
      refPresent_r <= 1'b0;
    end else if (refEdge) begin
      framesSinceRef_r <= 3'h0;
      refPresent_r <= 1'b1;
    end else if (inFrameStart) begin
      if (framesSinceRef_r >= `PCC_CADENCE_FRAMES) begin
        refPresent_r <= 1'b0;
      end else begin
        framesSinceRef_r <= framesSinceRef_r + 3'h1;
      end
    end
  end

  // cycles since last frame start, saturating
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sinceStart_r <= 5'h1F;
    end else if (inFrameStart) begin
      sinceStart_r <= 5'h0;
    end else if (sinceStart_r != 5'h1F) begin
      sinceStart_r <= sinceStart_r + 5'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // four-frame delay line, picture audio and timecode together

  pcc_pkg::pcc_in_frame_type frameMem [`PCC_DELAY_FRAMES];
  logic [`PCC_DELAY_FRAMES-1:0] refMark_r;
  logic [`PCC_DELAY_FRAMES-1:0] filled_r;
  logic [`PCC_SLOT_W-1:0] wrSlot_r;
  logic [`PCC_SLOT_W-1:0] lastSlot;
  logic launch;
  assign lastSlot = wrSlot_r - `PCC_SLOT_W'(1);
  assign launch = inFrameStart & filled_r[wrSlot_r];

  // oldest slot read as new frame written
  // audio rides in the same slot
  always_ff @(posedge mclk) begin
    if (inFrameStart) begin
      frameMem[wrSlot_r] <= inFrame;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrSlot_r <= '0;
      filled_r <= '0;
      frameCount_r <= 16'h0;
    end else if (inFrameStart) begin
      wrSlot_r <= wrSlot_r + `PCC_SLOT_W'(1);
      filled_r[wrSlot_r] <= 1'b1;
      frameCount_r <= frameCount_r + 16'h1;
    end
  end

  // mark the frame whose start the pulse met
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      refMark_r <= '0;
    end else if (inFrameStart) begin
      refMark_r[wrSlot_r] <= 1'b0;
    end else if (refEdge && sinceStart_r <= 5'(`PCC_REF_WIN_CYC)) begin
      refMark_r[lastSlot] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cadence phase

  pcc_pkg::pcc_in_frame_type oldFrame;
  logic isCandidate;
  logic [1:0] phaseNxt;
  assign oldFrame = frameMem[wrSlot_r];

  // reference or timecode chooses the start
  always_comb begin
    if (refEnable && refPresent_r) begin
      isCandidate = refMark_r[wrSlot_r];
    end else begin
      isCandidate = (oldFrame.tc.frames & `PCC_TC_MOD_MASK) == 6'h0;
    end
  end

  assign phaseNxt = isCandidate ? `PCC_PHASE_A : phase_r + 2'h1;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase_r <= `PCC_PHASE_A;
    end else if (launch) begin
      phase_r <= phaseNxt;
    end
  end

  // even phases two fields, odd three
  function automatic logic [1:0] fieldsFor(input logic [1:0] ph);
    fieldsFor = ph[0] ? `PCC_FIELDS_LONG : `PCC_FIELDS_SHORT;
  endfunction : fieldsFor

  ////////////////////////////////////////////////////////////////////////
  // field emitter

  pcc_pkg::pcc_emit_state_type state_r;
  pcc_pkg::pcc_in_frame_type cur_r;
  logic [1:0] fieldsLeft_r;
  logic [3:0] cadField_r;
  logic oddField_r;
  logic [4:0] groupBase_r;
  logic bufWrite;
  logic bufReady;
  pcc_pkg::pcc_out_field_type fieldNxt;

  assign bufWrite = (state_r == pcc_pkg::PCC_EMIT) & bufReady;

  // launch a delayed frame, emit its fields
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= pcc_pkg::PCC_IDLE;
      fieldsLeft_r <= 2'h0;
      overrun_r <= 1'b0;
    end else begin
      case (state_r)
        pcc_pkg::PCC_IDLE: begin
          if (launch) begin
            fieldsLeft_r <= fieldsFor(phaseNxt);
            state_r <= pcc_pkg::PCC_EMIT;
          end
        end
        pcc_pkg::PCC_EMIT: begin
          if (launch) begin
            overrun_r <= 1'b1;
          end
          if (bufWrite) begin
            fieldsLeft_r <= fieldsLeft_r - 2'h1;
            if (fieldsLeft_r == 2'h1) begin
              state_r <= pcc_pkg::PCC_IDLE;
            end
          end
        end
        default: state_r <= pcc_pkg::PCC_IDLE;
      endcase
    end
  end

  // frame held while its fields go out
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cur_r <= '0;
      groupBase_r <= 5'h0;
    end else if (launch && state_r == pcc_pkg::PCC_IDLE) begin
      cur_r <= oldFrame;
      // group of four film frames maps to five video frames
      groupBase_r <= 5'(oldFrame.tc.frames[4:2] * `PCC_TC_OUT_GROUP);
    end
  end

  // field position within the ten-field cadence
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cadField_r <= 4'h0;
      oddField_r <= 1'b1;
    end else if (launch && state_r == pcc_pkg::PCC_IDLE && phaseNxt == `PCC_PHASE_A) begin
      cadField_r <= 4'h0;
    end else if (bufWrite) begin
      cadField_r <= cadField_r + 4'h1;
      oddField_r <= ~oddField_r;
    end
  end

  // output field contents
  always_comb begin
    fieldNxt = '0;
    fieldNxt.picture = cur_r.picture;
    fieldNxt.audio = cur_r.audio;
    fieldNxt.tc = cur_r.tc;
    // output frame number at 30 per second
    fieldNxt.tc.frames = {1'b0, groupBase_r + {2'h0, cadField_r[3:1]}};
    fieldNxt.oddField = oddField_r;
    fieldNxt.cadence = phase_r;
    fieldNxt.lost = videoLost;
    fieldNxt.fill = pcc_pkg::pcc_fill_type'(ctrl_r[`PCC_CTRL_FILL_MSB:`PCC_CTRL_FILL_LSB]);
    fieldNxt.chars = ctrl_r[`PCC_CTRL_CHARS];
    // HD 4:2:2 or SD output selection
    fieldNxt.sdOut = ctrl_r[`PCC_CTRL_SD_OUT];
    fieldNxt.aspect = pcc_pkg::pcc_aspect_type'(ctrl_r[`PCC_CTRL_ASPECT_MSB:`PCC_CTRL_ASPECT_LSB]);
    fieldNxt.threeLineVitc = ctrl_r[`PCC_CTRL_FILM];
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry output buffer

  pcc_pkg::pcc_out_field_type bufMem [2];
  logic bufWr_r;
  logic bufRd_r;
  logic bufRead;
  assign bufReady = bufCount_r != 2'h2;
  assign outValid = bufCount_r != 2'h0;
  assign bufRead = outValid & outReady;

  // storage write
  always_ff @(posedge mclk) begin
    if (bufWrite) begin
      bufMem[bufWr_r] <= fieldNxt;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bufWr_r <= 1'b0;
      bufRd_r <= 1'b0;
      bufCount_r <= 2'h0;
    end else begin
      if (bufWrite) begin
        bufWr_r <= ~bufWr_r;
      end
      if (bufRead) begin
        bufRd_r <= ~bufRd_r;
      end
      case ({bufWrite, bufRead})
        2'b10: bufCount_r <= bufCount_r + 2'h1;
        2'b01: bufCount_r <= bufCount_r - 2'h1;
        default: bufCount_r <= bufCount_r;
      endcase
    end
  end

  // registered head of buffer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      outField <= '0;
    end else if (bufWrite && (bufCount_r == 2'h0 || (bufCount_r == 2'h1 && bufRead))) begin
      outField <= fieldNxt;
    end else if (bufRead) begin
      outField <= bufMem[~bufRd_r];
    end
  end

endmodule : pcc_cadence_converter

// file: pcc_cadence_converter_chk.sv
`timescale 1ns/100ps
`include "pcc_defines.svh"
// port checks for the cadence converter
module pcc_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire pcc_pkg::pcc_out_field_type outField,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [`PCC_ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic [31:0] regRdata
);
  logic acc;
  logic same;
  logic lastVld_r;
  logic lastOdd_r;
  logic [1:0] lastCad_r;
  logic [1:0] run_r;
  assign acc = outValid && outReady;
  assign same = lastVld_r && outField.cadence == lastCad_r;
  // last accepted field and run length
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lastVld_r <= 1'b0;
    end else if (acc) begin
      lastVld_r <= 1'b1;
      lastOdd_r <= outField.oddField;
      lastCad_r <= outField.cadence;
      run_r <= same ? run_r + 2'h1 : 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_run_len: assert property (
    acc && lastVld_r && !same |-> run_r == (lastCad_r[0] ? 2'h3 : 2'h2))
    else $error("field run length wrong");
  chk_run_max: assert property (
    acc && same |-> run_r < 2'h3)
    else $error("too many fields in a frame");
  chk_field_parity: assert property (
    acc && same |-> outField.oddField != lastOdd_r)
    else $error("field parity repeated");
  chk_stall_hold: assert property (
    outValid && !outReady |=> outValid && $stable(outField))
    else $error("stalled field changed");
  chk_rd_idle: assert property (
    !regRd |=> regRdata == 32'h0)
    else $error("read data without read");
  chk_unmapped_rd: assert property (
    regRd && regAddr != `PCC_REG_CTRL && regAddr != `PCC_REG_STATUS
      && regAddr != `PCC_REG_FRAMES |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  chk_status_top: assert property (
    regRd && regAddr == `PCC_REG_STATUS |=> regRdata[31:6] == 26'h0)
    else $error("status upper bits set");
  chk_frames_top: assert property (
    regRd && regAddr == `PCC_REG_FRAMES |=> regRdata[31:17] == 15'h0)
    else $error("frames upper bits set");
  chk_reset_out: assert property (
    $rose(reset_n) |-> !outValid && regRdata == 32'h0)
    else $error("outputs busy after reset");
  cov_stall: cover property (outValid && !outReady);
  cov_phase_a: cover property (acc && outField.cadence == 2'h0);
  cov_lost: cover property (acc && outField.lost);
endmodule : pcc_chk

bind pcc_cadence_converter pcc_chk u_chk (.mclk(mclk), .reset_n(reset_n),
  .outField(outField), .outValid(outValid), .outReady(outReady),
  .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata));

// file: pcc_src_model.sv
`timescale 1ns/100ps
// video source with reference pulse
module pcc_src_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic refOn,
  input wire logic lossOn,
  output logic inFrameStart = 1'b0,
  output pcc_pkg::pcc_in_frame_type inFrame = '0,
  output logic refPulsePin = 1'b0,
  output logic videoPresentPin = 1'b0
);
  int cyc = 0;
  logic [4:0] n = 5'h0;
  // a frame every 40 cycles, data scrambled between starts
  always @(posedge mclk) begin
    inFrameStart <= run && cyc == 0;
    cyc <= (run && cyc < 39) ? cyc + 1 : 0;
    n <= !run ? 5'h0 : n + 5'(cyc == 0);
    videoPresentPin <= run && !lossOn;
    if (run && cyc == 0) begin
      inFrame <= '{{11'h0, n}, ~{11'h0, n}, '{6'h01, 6'h02, 6'h03, {1'b0, n} + 6'h02}};
    end else begin
      inFrame <= ~inFrame;
    end
  end
  // pulse rises with frame start, held four cycles so the pin filter keeps it
  always @(posedge mclk) begin
    refPulsePin <= refOn && run && cyc < 4 && n[1:0] == ((cyc == 0) ? 2'h1 : 2'h2);
  end
endmodule : pcc_src_model

// file: pcc_cadence_converter_tb.sv
`timescale 1ns/100ps
`include "pcc_defines.svh"
// self-checking bench
module pcc_cadence_converter_tb;
  typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} pcc_row_type;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic refOn = 1'b0;
  logic lossOn = 1'b0;
  logic stallOn = 1'b0;
  logic tcChk = 1'b0;
  logic sawLost = 1'b0;
  logic inFrameStart;
  logic refPulsePin;
  logic videoPresentPin;
  logic outValid;
  logic outReady = 1'b1;
  logic [6:0] expFmt;
  logic [6:0] gotFmt;
  pcc_pkg::pcc_in_frame_type inFrame;
  pcc_pkg::pcc_out_field_type outField;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int phOff;
  int minP;
  int st [4] = '{0, 2, 5, 7};
  int startCyc [32];
  int firstCyc [32];
  int fields [32];
  pcc_row_type rows [10] = '{'{1'b1, 4'h0, 32'h03}, '{1'b0, 4'h0, 32'h03},
    '{1'b1, 4'h0, 32'hC5}, '{1'b0, 4'h0, 32'hC5}, '{1'b1, 4'h0, 32'hB9},
    '{1'b1, 4'h8, 32'hFFFF}, '{1'b0, 4'h8, 32'h0}, '{1'b1, 4'hC, 32'h5},
    '{1'b0, 4'hC, 32'h0}, '{1'b0, 4'h0, 32'hB9}};

  always #25 mclk = ~mclk;

  pcc_src_model u_src (.mclk(mclk), .run(run), .refOn(refOn), .lossOn(lossOn),
    .inFrameStart(inFrameStart), .inFrame(inFrame), .refPulsePin(refPulsePin),
    .videoPresentPin(videoPresentPin));

  pcc_cadence_converter u_dut (.mclk(mclk), .reset_n(reset_n),
    .inFrameStart(inFrameStart), .inFrame(inFrame), .refPulsePin(refPulsePin),
    .videoPresentPin(videoPresentPin), .outField(outField), .outValid(outValid),
    .outReady(outReady), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));

  // format flags carried with each field
  assign gotFmt = {outField.fill, outField.chars, outField.threeLineVitc, outField.sdOut,
    outField.aspect};

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  // register bus cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic hardReset();
    reset_n <= 1'b0;
    lossOn <= 1'b0;
    refOn <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
  endtask : hardReset

  // fourteen frames, loss near the end when tcChk is set, then drain
  task automatic stream();
    foreach (fields[i]) begin
      fields[i] = 0;
      firstCyc[i] = -1;
    end
    run <= 1'b1;
    repeat (500) @(posedge mclk);
    lossOn <= tcChk;
    repeat (55) @(posedge mclk);
    run <= 1'b0;
    repeat (60) @(posedge mclk);
    for (int p = 0; p < 9; p++) begin
      if (p >= minP) chk(fields[p], (p + phOff) % 2 ? 3 : 2, "field count");
      if (!stallOn) chk(firstCyc[p] - startCyc[p + 4], 2, "latency");
    end
  endtask : stream

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // output monitor and stall pattern
  always @(posedge mclk) begin : mon
    int p;
    int k;
    int c;
    cyc++;
    outReady <= !stallOn || cyc % 40 > 19;
    if (inFrameStart) startCyc[inFrame.picture[4:0]] = cyc;
    p = outField.picture[4:0];
    if (outValid && firstCyc[p] < 0) firstCyc[p] = cyc;
    if (outValid && outReady) begin
      k = fields[p];
      c = (p + phOff) % 4;
      fields[p]++;
      chk({16'h0, outField.audio}, {16'h0, ~16'(p)}, "audio");
      chk({25'h0, gotFmt}, {25'h0, expFmt}, "format");
      if (p < 7) chk(outField.lost, 1'b0, "lost flag");
      if (outField.lost === 1'b1 && outField.fill === pcc_pkg::PCC_FILL_BLACK) sawLost = 1'b1;
      if (p >= minP && outField.lost !== 1'b1) begin
        chk(outField.cadence, c[1:0], "phase");
        if (tcChk) chk(outField.tc.frames, (p + 2) / 4 * 5 + (st[c] + k) / 2, "tc");
      end
    end
  end

  // main sequence
  initial begin : main
    logic [31:0] d;
    hardReset();
    rd(`PCC_REG_CTRL, d);
    chk(d, 32'h11, "ctrl reset");
    rd(`PCC_REG_STATUS, d);
    chk(d[1], 1'b1, "video lost");
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, d);
        chk(d, rows[i].d, "register row");
      end
    end
    $display("register rows done");
    wr(`PCC_REG_CTRL, 32'h31);
    phOff = 3;
    minP = 1;
    expFmt = 7'h05;
    refOn <= 1'b1;
    stallOn <= 1'b1;
    stream();
    rd(`PCC_REG_FRAMES, d);
    chk(d, 32'hE, "frame count");
    rd(`PCC_REG_STATUS, d);
    chk(d[0], 1'b1, "ref present");
    $display("reference test done");
    hardReset();
    wr(`PCC_REG_CTRL, 32'hDB);
    phOff = 2;
    minP = 2;
    expFmt = 7'h3E;
    tcChk <= 1'b1;
    stallOn <= 1'b0;
    stream();
    rd(`PCC_REG_STATUS, d);
    chk(d[0], 1'b0, "ref absent");
    chk(sawLost, 1'b1, "loss fill");
    $display("timecode test done");
    end_of_test();
  end
endmodule : pcc_cadence_converter_tb
